/* rtl/scp_pkg.sv */
// Constants shared by the serial command port and its link-side helpers
package scp_pkg;

    // Frame shape on the serial link
    localparam int          BYTE_BITS        = 8;
    localparam int          EDGE_CNT_W       = 5;
    localparam logic [4:0]  MIN_BYTE_EDGES   = 5'h08;
    localparam logic [4:0]  LONG_FRAME_EDGES = 5'h10;

    // Channels
    localparam int          NUM_CHAN         = 4;
    localparam int          SAMPLE_BITS      = 16;
    localparam logic [1:0]  SAMPLE_BYTES     = 2'h2;

    // Command codes handled inside the port
    localparam logic [7:0]  CMD_DEACTIVATE   = 8'h00;
    localparam logic [7:0]  CMD_SOFT_RESET   = 8'h02;
    localparam logic [7:0]  CMD_HARD_RESET   = 8'h04;
    localparam logic [7:0]  CMD_NOP          = 8'h06;
    localparam logic [7:0]  CMD_ACTIVATE     = 8'h0e;
    localparam logic [7:0]  CMD_WR_ENABLE    = 8'h4a;
    localparam logic [7:0]  CMD_RD_ENABLE    = 8'h4b;
    localparam logic [7:0]  CMD_RD_REALTIME  = 8'h4d;
    localparam logic [7:0]  CMD_RD_RT_CLEAR  = 8'h4f;
    localparam logic [7:0]  CMD_RD_STATUS    = 8'h55;
    localparam logic [7:0]  CMD_RD_REVISION  = 8'h73;
    localparam logic [7:0]  CMD_RD_TX_SAMPLE = 8'hcd;

    // Field positions and values after reset
    localparam int          ENABLE_LSB       = 0;
    localparam int          ACTIVE_FLAG_BIT  = 0;
    localparam logic [7:0]  ENABLE_REG_RESET = 8'h0f;
    localparam logic [3:0]  ACTIVE_RESET     = 4'h0;
    localparam logic [7:0]  TX_IDLE_BYTE     = 8'h00;

endpackage

/* rtl/bit_sync.sv */
// Two-flop synchroniser for levels and quasi-static words
`timescale 1ns/10ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) $error("bit_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* rtl/link_frame.sv */
// Link-side shifter: counts rising edges per frame, shifts bytes in and out
`timescale 1ns/10ps
module link_frame
    import scp_pkg::*;
(
    input  wire logic                  sclk_in,
    input  wire logic                  cs_n_in,
    input  wire logic                  nrst_in,
    input  wire logic                  sdi_in,
    input  wire logic [BYTE_BITS-1:0]  tx_byte_in,
    output logic      [BYTE_BITS-1:0]  rx_byte_out,
    output logic      [EDGE_CNT_W-1:0] edges_out,
    output logic                       seq_out,
    output logic                       sdo_out
);
    logic       first_q;
    logic [2:0] out_idx_q;

    // Armed whenever chip select is high; the first rising edge of a frame clears it
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // Edge count survives chip select high so the core can read it after the frame
    always_ff @(posedge sclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            edges_out <= '0;
            seq_out   <= 1'b0;
        end else if (!cs_n_in) begin
            if (first_q) begin
                edges_out <= 5'h01;
                seq_out   <= ~seq_out;
            end else if (edges_out != LONG_FRAME_EDGES) begin
                edges_out <= edges_out + 5'h01;
            end
        end
    end

    // Input bits taken on rising edges, MSB first; the last eight stay in the register
    always_ff @(posedge sclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_byte_out <= '0;
        end else if (!cs_n_in) begin
            rx_byte_out <= {rx_byte_out[BYTE_BITS-2:0], sdi_in};
        end
    end

    // Output bit moves on falling edges, only once a rising edge has sampled it
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            out_idx_q <= 3'h0;
        end else if (!first_q) begin
            out_idx_q <= edges_out[2:0];
        end
    end

    // D7 is on the line from the moment chip select falls
    assign sdo_out = tx_byte_in[3'h7 - out_idx_q];
endmodule

/* rtl/serial_command_port.sv */
// Serial command port: frames host bytes, decodes commands, sequences reads
`timescale 1ns/10ps
module serial_command_port
    import scp_pkg::*;
#(
    parameter int NCH = NUM_CHAN
) (
    input  wire logic                      core_clk_in,
    input  wire logic                      nrst_in,
    input  wire logic                      serial_shift_clock_in,
    input  wire logic                      cs_n_in,
    input  wire logic                      serial_data_line_in,
    output logic                           serial_data_line_out,
    output logic                           serial_data_line_oe_out,
    input  wire logic [NCH*SAMPLE_BITS-1:0] tx_sample_word_in,
    input  wire logic [BYTE_BITS-1:0]      realtime_input_bits_in,
    input  wire logic [BYTE_BITS-1:0]      rd_data_in,
    output logic [NCH-1:0]                 channel_enable_reg_out,
    output logic [NCH-1:0]                 channel_active_flag_out,
    output logic                           wr_strobe_out,
    output logic [BYTE_BITS-1:0]           wr_cmd_out,
    output logic [BYTE_BITS-1:0]           wr_data_out,
    output logic [NCH-1:0]                 wr_chan_mask_out,
    output logic                           rd_req_out,
    output logic [BYTE_BITS-1:0]           rd_cmd_out,
    output logic [1:0]                     rd_chan_out,
    output logic                           soft_reset_out,
    output logic [NCH-1:0]                 soft_reset_mask_out,
    output logic                           hw_reset_out,
    output logic                           int_clear_out,
    output logic                           runt_frame_out,
    output logic                           cmd_busy_out
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_FETCH,
        ST_READ
    } state_t;

    localparam int SYNC_W = 2 + EDGE_CNT_W + BYTE_BITS;

    initial begin
        if (NCH != NUM_CHAN) $error("serial_command_port: NCH must be 4");
    end

    // Lowest set bit of the enable mask, channel 0 when none is set
    function automatic logic [1:0] first_chan(input logic [NCH-1:0] en);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (en[i]) idx = 2'(i);
        end
        return idx;
    endfunction

    // Channel registers kept outside the port, one data byte each
    function automatic logic is_ext_reg(input logic [6:0] pair);
        logic hit;
        hit = 1'b0;
        unique case (pair)
            7'h20, 7'h21, 7'h22, 7'h23, 7'h28,
            7'h29, 7'h2a, 7'h30, 7'h36, 7'h38, 7'h64, 7'h74: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Link side
    logic [BYTE_BITS-1:0]  link_rx_byte;
    logic [EDGE_CNT_W-1:0] link_edges;
    logic                  link_seq;
    logic                  link_sdo;
    logic [BYTE_BITS-1:0]  tx_byte_q;

    link_frame u_link (
        .sclk_in     (serial_shift_clock_in),
        .cs_n_in     (cs_n_in),
        .nrst_in     (nrst_in),
        .sdi_in      (serial_data_line_in),
        .tx_byte_in  (tx_byte_q),
        .rx_byte_out (link_rx_byte),
        .edges_out   (link_edges),
        .seq_out     (link_seq),
        .sdo_out     (link_sdo)
    );

    // Crossing into the core clock; the words are stable once chip select is high
    logic [SYNC_W-1:0]     sync_word;
    logic                  cs_n_s;
    logic                  seq_s;
    logic [EDGE_CNT_W-1:0] edges_s;
    logic [BYTE_BITS-1:0]  byte_s;

    bit_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_in   (core_clk_in),
        .nrst_in  (nrst_in),
        .async_in ({cs_n_in, link_seq, link_edges, link_rx_byte}),
        .sync_out (sync_word)
    );

    assign {cs_n_s, seq_s, edges_s, byte_s} = sync_word;

    // Frame end detection
    logic cs_n_prev_q;
    logic seq_seen_q;
    logic frame_end;
    logic frame_has_edges;
    logic byte_valid;
    logic long_frame;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cs_n_prev_q <= 1'b1;
            seq_seen_q  <= 1'b0;
        end else begin
            cs_n_prev_q <= cs_n_s;
            if (frame_end) begin
                seq_seen_q <= seq_s;
            end
        end
    end

    assign frame_end       = cs_n_s & ~cs_n_prev_q;
    assign frame_has_edges = frame_end & (seq_s != seq_seen_q);
    assign long_frame      = frame_has_edges & (edges_s >= LONG_FRAME_EDGES);
    assign byte_valid      = frame_has_edges & (edges_s >= MIN_BYTE_EDGES)
                             & ~long_frame;

    // Command decode
    state_t               state_q;
    logic [1:0]           bytes_left_q;
    logic [BYTE_BITS-1:0] cmd_q;
    logic [BYTE_BITS-1:0] tx_next_q;
    logic [BYTE_BITS-1:0] enable_reg_q;
    logic [NCH-1:0]       active_q;
    logic [NCH-1:0]       enables;
    logic [1:0]           rd_chan;
    logic [SAMPLE_BITS-1:0] sample_sel;
    logic                 full_reset;
    logic                 is_cmd;

    assign enables    = enable_reg_q[ENABLE_LSB +: NCH];
    assign rd_chan    = first_chan(enables);
    assign sample_sel = tx_sample_word_in[rd_chan*SAMPLE_BITS +: SAMPLE_BITS];
    assign is_cmd     = byte_valid & (state_q == ST_IDLE);
    assign full_reset = long_frame
                        | (is_cmd & (byte_s == CMD_HARD_RESET));

    // Sequencer: command, then N input bytes or N output bytes
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q      <= ST_IDLE;
            bytes_left_q <= 2'h0;
            cmd_q        <= '0;
        end else if (full_reset) begin
            state_q      <= ST_IDLE;
            bytes_left_q <= 2'h0;
            cmd_q        <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (is_cmd) begin
                        cmd_q <= byte_s;
                        if (byte_s == CMD_WR_ENABLE
                            || (!byte_s[0] && is_ext_reg(byte_s[7:1]))) begin
                            state_q      <= ST_WRITE;
                            bytes_left_q <= 2'h1;
                        end else if (byte_s == CMD_RD_TX_SAMPLE) begin
                            state_q      <= ST_READ;
                            bytes_left_q <= SAMPLE_BYTES;
                        end else if (byte_s == CMD_RD_ENABLE
                                     || byte_s == CMD_RD_REALTIME
                                     || byte_s == CMD_RD_RT_CLEAR) begin
                            state_q      <= ST_READ;
                            bytes_left_q <= 2'h1;
                        end else if (byte_s == CMD_RD_STATUS
                                     || byte_s == CMD_RD_REVISION
                                     || (byte_s[0] && is_ext_reg(byte_s[7:1]))) begin
                            state_q      <= ST_FETCH;
                            bytes_left_q <= 2'h1;
                        end
                    end
                end
                ST_WRITE: begin
                    if (byte_valid) begin
                        bytes_left_q <= bytes_left_q - 2'h1;
                        if (bytes_left_q == 2'h1) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_FETCH: begin
                    state_q <= ST_READ;
                end
                ST_READ: begin
                    if (byte_valid) begin
                        bytes_left_q <= bytes_left_q - 2'h1;
                        if (bytes_left_q == 2'h1) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Output byte for the link and the one queued behind it
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_byte_q <= TX_IDLE_BYTE;
            tx_next_q <= TX_IDLE_BYTE;
        end else if (full_reset) begin
            tx_byte_q <= TX_IDLE_BYTE;
            tx_next_q <= TX_IDLE_BYTE;
        end else if (is_cmd) begin
            unique case (byte_s)
                CMD_RD_ENABLE: begin
                    tx_byte_q <= enable_reg_q;
                end
                CMD_RD_REALTIME, CMD_RD_RT_CLEAR: begin
                    tx_byte_q <= realtime_input_bits_in;
                end
                CMD_RD_TX_SAMPLE: begin
                    tx_byte_q <= sample_sel[SAMPLE_BITS-1 -: BYTE_BITS];
                    tx_next_q <= sample_sel[BYTE_BITS-1:0];
                end
                default: begin
                    tx_byte_q <= TX_IDLE_BYTE;
                end
            endcase
        end else if (state_q == ST_FETCH) begin
            tx_byte_q <= rd_data_in;
            if (cmd_q == CMD_RD_STATUS) begin
                tx_byte_q[ACTIVE_FLAG_BIT] <= active_q[rd_chan];
            end
        end else if (state_q == ST_READ && byte_valid) begin
            tx_byte_q <= tx_next_q;
            tx_next_q <= TX_IDLE_BYTE;
        end
    end

    // Channel enable register
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            enable_reg_q <= ENABLE_REG_RESET;
        end else if (full_reset) begin
            enable_reg_q <= ENABLE_REG_RESET;
        end else if (state_q == ST_WRITE && byte_valid && cmd_q == CMD_WR_ENABLE) begin
            enable_reg_q <= byte_s;
        end
    end

    // Per-channel active flags
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            active_q <= ACTIVE_RESET;
        end else if (full_reset) begin
            active_q <= ACTIVE_RESET;
        end else if (is_cmd && byte_s == CMD_ACTIVATE) begin
            active_q <= active_q | enables;
        end else if (is_cmd && byte_s == CMD_DEACTIVATE) begin
            active_q <= active_q & ~enables;
        end
    end

    // Writes fanned out to every enabled channel in one strobe
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_strobe_out    <= 1'b0;
            wr_cmd_out       <= '0;
            wr_data_out      <= '0;
            wr_chan_mask_out <= '0;
        end else begin
            wr_strobe_out <= 1'b0;
            if (!full_reset && state_q == ST_WRITE && byte_valid
                && cmd_q != CMD_WR_ENABLE) begin
                wr_strobe_out    <= 1'b1;
                wr_cmd_out       <= cmd_q;
                wr_data_out      <= byte_s;
                wr_chan_mask_out <= enables;
            end
        end
    end

    // Read requests to the lowest enabled channel
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_req_out  <= 1'b0;
            rd_cmd_out  <= '0;
            rd_chan_out <= 2'h0;
        end else begin
            rd_req_out <= 1'b0;
            if (is_cmd && !full_reset
                && (byte_s == CMD_RD_STATUS || byte_s == CMD_RD_REVISION
                    || (byte_s[0] && is_ext_reg(byte_s[7:1])))) begin
                rd_req_out  <= 1'b1;
                rd_cmd_out  <= byte_s;
                rd_chan_out <= rd_chan;
            end
        end
    end

    // One-cycle command pulses, plus the soft-reset channel mask held until the next soft reset
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            soft_reset_out      <= 1'b0;
            soft_reset_mask_out <= '0;
            hw_reset_out        <= 1'b0;
            int_clear_out       <= 1'b0;
            runt_frame_out      <= 1'b0;
        end else begin
            soft_reset_out <= is_cmd && byte_s == CMD_SOFT_RESET;
            if (is_cmd && byte_s == CMD_SOFT_RESET) begin
                soft_reset_mask_out <= enables;
            end
            hw_reset_out   <= full_reset;
            int_clear_out  <= is_cmd && byte_s == CMD_RD_RT_CLEAR;
            runt_frame_out <= frame_has_edges && edges_s < MIN_BYTE_EDGES;
        end
    end

    // Status levels
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            channel_enable_reg_out  <= ENABLE_REG_RESET[ENABLE_LSB +: NCH];
            channel_active_flag_out <= ACTIVE_RESET;
            cmd_busy_out            <= 1'b0;
        end else begin
            channel_enable_reg_out  <= enables;
            channel_active_flag_out <= active_q;
            cmd_busy_out            <= state_q != ST_IDLE;
        end
    end

    // Drive the data line only inside a frame of a pending read
    assign serial_data_line_out    = link_sdo;
    assign serial_data_line_oe_out = (state_q == ST_READ) & ~cs_n_in;

endmodule

/* bench/scp_properties.sv */
// Concurrent checks on the serial command port ports
`timescale 1ns/10ps
module scp_properties
    import scp_pkg::*;
#(
    parameter int NCH = NUM_CHAN
) (
    input wire logic           core_clk_in,
    input wire logic           nrst_in,
    input wire logic           cs_n_in,
    input wire logic           serial_data_line_oe_out,
    input wire logic [NCH-1:0] channel_enable_reg_out,
    input wire logic [NCH-1:0] channel_active_flag_out,
    input wire logic           wr_strobe_out,
    input wire logic [7:0]     wr_cmd_out,
    input wire logic [NCH-1:0] wr_chan_mask_out,
    input wire logic           rd_req_out,
    input wire logic [1:0]     rd_chan_out,
    input wire logic           hw_reset_out,
    input wire logic           int_clear_out,
    input wire logic           runt_frame_out,
    input wire logic           cmd_busy_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    function automatic logic [1:0] lowest(input logic [NCH-1:0] e);
        lowest = 2'h0;
        for (int i = NCH-1; i >= 0; i--) begin
            if (e[i]) lowest = i[1:0];
        end
    endfunction
    a_oe_in_frame: assert property (serial_data_line_oe_out |-> !cs_n_in)
        else $error("data line driven outside a frame");
    a_oe_when_busy: assert property (serial_data_line_oe_out |-> cmd_busy_out)
        else $error("data line driven with no read pending");
    a_wr_mask_enables: assert property (wr_strobe_out && wr_cmd_out != CMD_WR_ENABLE
        |-> wr_chan_mask_out == channel_enable_reg_out)
        else $error("write mask differs from enables");
    a_wr_pulse_once: assert property (wr_strobe_out |=> !wr_strobe_out)
        else $error("write strobe longer than one cycle");
    a_rd_lowest_chan: assert property (rd_req_out
        |-> rd_chan_out == lowest(channel_enable_reg_out) && $past(rd_req_out) == 1'b0)
        else $error("read channel is not the lowest enabled");
    a_hw_reset_state: assert property (hw_reset_out |-> ##[0:2]
        (channel_enable_reg_out == ENABLE_REG_RESET[NCH-1:0] && channel_active_flag_out == '0))
        else $error("full reset left state behind");
    a_int_clear_pulse: assert property (int_clear_out |=> !int_clear_out)
        else $error("interrupt clear longer than one cycle");
    a_idle_cs_stable: assert property (cs_n_in [*8] |=> $stable(channel_enable_reg_out))
        else $error("enables changed with chip select idle");
    a_runt_no_effect: assert property (runt_frame_out |=> $stable(channel_enable_reg_out) [*4])
        else $error("short frame changed enables");
endmodule
bind serial_command_port scp_properties #(.NCH(NCH)) u_props (.core_clk_in, .nrst_in, .cs_n_in,
    .serial_data_line_oe_out, .channel_enable_reg_out, .channel_active_flag_out, .wr_strobe_out,
    .wr_cmd_out, .wr_chan_mask_out, .rd_req_out, .rd_chan_out, .hw_reset_out, .int_clear_out,
    .runt_frame_out, .cmd_busy_out);

/* bench/scp_host.sv */
// Host processor model: frames bytes on chip select and shift clock
`timescale 1ns/10ps
module scp_host (
    output logic       sclk_out,
    output logic       cs_n_out,
    output logic       sdi_out,
    input  wire logic  line_in,
    output logic [7:0] rx_out,
    output logic       rx_done_out
);
    initial begin
        {sclk_out, cs_n_out, sdi_out, rx_done_out} = 4'hc;
        rx_out = 8'h00;
    end
    // Clock rests high between frames except in idle_clk; n bits per chip-select low, the byte in the last eight
    task automatic frame(input int n, input logic [7:0] b, input bit rd);
        cs_n_out = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b0;
            sdi_out = rd ? ~sdi_out : (i >= n-8 ? b[n-1-i] : 1'b0);
            #16 sclk_out = 1'b1;
            rx_out = {rx_out[6:0], line_in};
            #16;
        end
        #40 cs_n_out = 1'b1;
        if (rd) begin
            rx_done_out = 1'b1;
            #1 rx_done_out = 1'b0;
        end
        #1200;
    endtask
    task automatic idle_clk(input int n);
        repeat (n) begin
            #16 sclk_out = 1'b0;
            #16 sclk_out = 1'b1;
        end
    endtask
endmodule

/* bench/test_serial_command_port.sv */
// Self-checking bench for the serial command port
`timescale 1ns/10ps
module test_serial_command_port
    import scp_pkg::*;
;
    logic        core_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [63:0] tx_w = 64'h0;
    logic [7:0]  rt = 8'h00;
    logic [7:0]  rdd = 8'h00;
    logic [31:0] seed = 32'h00007ff8;
    logic [31:0] exp_q[$];
    logic [7:0]  d;
    logic [7:0]  rx;
    logic [3:0]  en, act;
    logic [7:0]  wcmd, wdat;
    logic [3:0]  wmask;
    logic        sclk, cs_n, sdi, dout, oe, rx_done, wst, hwr, icl, runt;
    logic        rrq, srst, busy;
    logic [7:0]  rcmd;
    logic [1:0]  rch;
    logic [3:0]  smask;
    int          num_errors = 0;
    int          checks = 0;
    wire         line = oe ? dout : sdi;
    always #50 core_clk_in = ~core_clk_in;
    scp_host host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .line_in(line),
        .rx_out(rx), .rx_done_out(rx_done));
    serial_command_port uut (.core_clk_in, .nrst_in, .serial_shift_clock_in(sclk),
        .cs_n_in(cs_n), .serial_data_line_in(line), .serial_data_line_out(dout),
        .serial_data_line_oe_out(oe), .tx_sample_word_in(tx_w), .realtime_input_bits_in(rt),
        .rd_data_in(rdd), .channel_enable_reg_out(en), .channel_active_flag_out(act),
        .wr_strobe_out(wst), .wr_cmd_out(wcmd), .wr_data_out(wdat), .wr_chan_mask_out(wmask),
        .rd_req_out(rrq), .rd_cmd_out(rcmd), .rd_chan_out(rch), .soft_reset_out(srst),
        .soft_reset_mask_out(smask), .hw_reset_out(hwr), .int_clear_out(icl),
        .runt_frame_out(runt), .cmd_busy_out(busy));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        checks++;
        if (a !== e) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic got(input logic [31:0] a);
        chk(a, exp_q.size() > 0 ? exp_q.pop_front() : 32'hffffffff);
    endtask
    always @(negedge core_clk_in) begin
        if (wst && wcmd !== CMD_WR_ENABLE) got({8'h01, wcmd, wdat, 4'h0, wmask});
        if (hwr) got(32'h03000000);
        if (icl) got(32'h04000000);
        if (runt) got(32'h05000000);
        if (rrq) got({8'h07, rcmd, 14'h0, rch});
        if (srst) got({8'h06, 20'h0, smask});
    end
    always @(posedge rx_done) got({8'h02, 16'h0, rx});
    task automatic send(input int n, input logic [7:0] b);
        @(posedge core_clk_in);
        #5 host.frame(n, b, 1'b0);
    endtask
    task automatic rdf(input logic [7:0] e);
        exp_q.push_back({8'h02, 16'h0, e});
        @(posedge core_clk_in);
        #5 host.frame(8, 8'h00, 1'b1);
    endtask
    task automatic summarize;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #300000 num_errors++;
        summarize;
    end
    initial begin
        tx_w = {rnd(), rnd()};
        rt = 8'(rnd());
        rdd = 8'(rnd());
        d = 8'(rnd());
        repeat (16) @(posedge core_clk_in);
        #5 nrst_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        chk({24'h0, en, act}, 32'hf0);
        send(8, CMD_WR_ENABLE);
        chk({31'h0, busy}, 32'h1);
        send(8, 8'h06);
        host.idle_clk(40);
        chk({28'h0, en}, 32'h6);
        exp_q.push_back(32'h05000000);
        exp_q.push_back({8'h01, 8'h46, d, 8'h06});
        send(8, 8'h46);
        send(5, 8'hff);
        send(12, d);
        send(8, CMD_RD_ENABLE);
        rdf(8'h06);
        send(8, CMD_ACTIVATE);
        chk({28'h0, act}, 32'h6);
        exp_q.push_back({8'h07, CMD_RD_STATUS, 16'h1});
        send(8, CMD_RD_STATUS);
        rdf({rdd[7:1], 1'b1});
        send(8, CMD_WR_ENABLE);
        send(8, 8'h02);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) exp_q.push_back(32'h04000000);
            send(8, k == 1 ? CMD_RD_RT_CLEAR : CMD_RD_REALTIME);
            rdf(rt);
        end
        send(8, CMD_RD_TX_SAMPLE);
        rdf(tx_w[31:24]);
        rdf(tx_w[23:16]);
        send(8, CMD_DEACTIVATE);
        chk({28'h0, act}, 32'h4);
        exp_q.push_back({8'h06, 24'h2});
        send(8, CMD_SOFT_RESET);
        exp_q.push_back(32'h03000000);
        send(8, CMD_HARD_RESET);
        chk({28'h0, en}, 32'hf);
        send(8, CMD_WR_ENABLE);
        send(8, 8'h03);
        chk({28'h0, en}, 32'h3);
        exp_q.push_back(32'h03000000);
        send(16, 8'h00);
        chk({28'h0, en}, 32'hf);
        chk(32'(exp_q.size()), 32'h0);
        summarize;
    end
endmodule
